// *** rtl/bwpl_regs.svh ***
// Register offsets, field positions, opcodes and reset values of the block write protect logic.
// Assumes a 32-bit classic Wishbone slave; offsets are byte addresses.
`ifndef BWPL_REGS_SVH
`define BWPL_REGS_SVH

// ==========================================================
// Register offsets
`define BWPL_OFF_STATUS 8'h00
`define BWPL_OFF_CONFIG 8'h04
`define BWPL_OFF_RESULT 8'h08

// ==========================================================
// Status byte fields
`define BWPL_SR_WIP 0
`define BWPL_SR_WR_LATCH 1
`define BWPL_SR_BP_LO 2
`define BWPL_SR_BP_HI 5
`define BWPL_SR_QUAD 6
`define BWPL_SR_SWD 7
`define BWPL_SR_RESET 8'h00

// ==========================================================
// Config fields
`define BWPL_CFG_ORG256 0
`define BWPL_CFG_ADDR4 1
`define BWPL_CFG_BOTTOM 2
`define BWPL_CFG_RESET 3'h0

// ==========================================================
// Array geometry
`define BWPL_BLK64_SHIFT 16
`define BWPL_BLK256_SHIFT 18
`define BWPL_BLK64_TOTAL 11'h400
`define BWPL_BLK256_TOTAL 11'h100

// ==========================================================
// Opcodes
`define BWPL_OP_WR_ENABLE 8'h06
`define BWPL_OP_WRDI 8'h04
`define BWPL_OP_STATUS_WR 8'h01
`define BWPL_OP_PP3 8'h02
`define BWPL_OP_PP4 8'h12
`define BWPL_OP_PPQ3A 8'h32
`define BWPL_OP_PPQ3B 8'h38
`define BWPL_OP_PPQ4A 8'h34
`define BWPL_OP_PPQ4B 8'h3e
`define BWPL_OP_SE3A 8'hd7
`define BWPL_OP_SE3B 8'h20
`define BWPL_OP_SE4 8'h21
`define BWPL_OP_BE32_3 8'h52
`define BWPL_OP_BE32_4 8'h5c
`define BWPL_OP_BE64_3 8'hd8
`define BWPL_OP_BE64_4 8'hdc
`define BWPL_OP_CHIP_A 8'hc7
`define BWPL_OP_CHIP_B 8'h60
`define BWPL_OP_RDPV_NOWE 8'hc0
`define BWPL_OP_RDPV_WE 8'h63
`define BWPL_OP_BANKV_NOWE 8'h17
`define BWPL_OP_BANKV_WE 8'hc5

`endif

// *** rtl/bwpl_pkg.sv ***
// Types shared by the block write protect logic.
// Assumes bwpl_regs.svh for all numeric constants.
package bwpl_pkg;

   // ==========================================================
   // Array operation kinds
   typedef enum logic [2:0] {
      BWPL_PROG,
      BWPL_ERASE_4K,
      BWPL_ERASE_32K,
      BWPL_ERASE_64K,
      BWPL_ERASE_CHIP,
      BWPL_STATUS_WR
   } bwpl_op_e;

   typedef struct packed {
      logic cs_n;
      logic sck;
      logic si;
      logic wp;
      logic hold;
   } bwpl_pins_s;

   typedef struct packed {
      logic valid;
      bwpl_op_e kind;
      logic [31:0] addr;
   } bwpl_req_s;

   typedef struct packed {
      logic valid;
      logic [7:0] opcode;
      logic [7:0] data;
   } bwpl_vol_s;

   typedef struct packed {
      bwpl_pins_s sync1;
      bwpl_pins_s sync2;
      logic prev_cs_n;
      logic prev_sck;
      logic [2:0] bit_cnt;
      logic [7:0] shift;
      logic have_op;
      logic [7:0] opcode;
      logic [2:0] nbytes;
      logic [31:0] acc;
      logic [7:0] status;
      logic [2:0] cfg;
      logic [11:0] result;
      bwpl_req_s req;
      bwpl_vol_s vol;
      logic refused;
      logic wb_ack;
      logic [31:0] wb_dat;
   } bwpl_state_s;

endpackage

// *** rtl/bwpl_block_write_protect.sv ***
// Write protection core of a serial flash: command front end, protect range, status lock.
// Assumes SPI pins arrive asynchronously, an array engine that pulses array_done,
// and a classic Wishbone master for the register file.
`timescale 1ns/1ps
`include "bwpl_regs.svh"

module bwpl_block_write_protect #(
   parameter int ADDR_W = 26
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Serial link pins
   input wire logic cs_n_pin,
   input wire logic sck_pin,
   input wire logic si_pin,
   input wire logic data_line_two_i,
   output logic data_line_two_o,
   output logic data_line_two_oe,
   input wire logic data_line_three_i,
   output logic data_line_three_o,
   output logic data_line_three_oe,
   // Array engine
   output logic op_valid,
   output bwpl_pkg::bwpl_op_e op_kind,
   output logic [31:0] op_addr,
   input wire logic array_done,
   // Volatile parameter writes
   output logic vol_valid,
   output logic [7:0] vol_opcode,
   output logic [7:0] vol_data,
   // Status
   output logic cmd_refused,
   output logic [7:0] status_reg,
   output logic quad_mode,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o
);

   // ==========================================================
   // Protect range
   function automatic logic [10:0] prot_count(input logic [3:0] code, input logic org256);
      logic [10:0] cnt;
      cnt = 11'h000;
      if (code != 4'h0) begin
         if (org256) begin
            if (code <= 4'h8) begin
               cnt = 11'h001 << (code - 4'h1);
            end else begin
               cnt = `BWPL_BLK256_TOTAL;
            end
         end else begin
            unique case (code)
               4'hb: cnt = 11'h300;
               4'hc: cnt = 11'h380;
               4'hd: cnt = 11'h3c0;
               4'he: cnt = 11'h3e0;
               4'hf: cnt = `BWPL_BLK64_TOTAL;
               default: cnt = 11'h001 << (code - 4'h1);
            endcase
         end
      end
      return cnt;
   endfunction

   bwpl_pkg::bwpl_state_s s_ff;
   bwpl_pkg::bwpl_state_s nxt_s;
   bwpl_pkg::bwpl_pins_s pins_in;

   logic quad_en;
   logic wp_level;
   logic hold_active;
   logic cs_fall;
   logic cs_rise;
   logic sck_rise;
   logic [7:0] shifted;
   logic is_prog;
   logic is_e4;
   logic is_e32;
   logic is_e64;
   logic is_chip;
   logic is_addr4;
   logic [2:0] need;
   logic len_ok;
   logic [31:0] target;
   logic [9:0] blk;
   logic [10:0] total;
   logic [10:0] pcnt;
   logic hit;
   logic wr_latch;
   logic wb_req;
   logic [31:0] rd_dat;

   assign pins_in = '{cs_n: cs_n_pin, sck: sck_pin, si: si_pin,
                      wp: data_line_two_i, hold: data_line_three_i};

   // ==========================================================
   // Pin roles
   assign quad_en = s_ff.status[`BWPL_SR_QUAD];
   // With quad on the protect pin is a data line, so the lock cannot be asserted
   assign wp_level = quad_en | s_ff.sync2.wp;
   assign hold_active = ~quad_en & ~s_ff.sync2.hold;
   // No read path here, so the data lines are never driven
   assign data_line_two_o = 1'b0;
   assign data_line_two_oe = 1'b0;
   assign data_line_three_o = 1'b0;
   assign data_line_three_oe = 1'b0;
   assign quad_mode = quad_en;

   assign cs_fall = s_ff.prev_cs_n & ~s_ff.sync2.cs_n;
   assign cs_rise = ~s_ff.prev_cs_n & s_ff.sync2.cs_n;
   assign sck_rise = ~s_ff.prev_sck & s_ff.sync2.sck & ~s_ff.sync2.cs_n & ~hold_active;
   assign shifted = {s_ff.shift[6:0], s_ff.sync2.si};

   // ==========================================================
   // Opcode decode
   always_comb begin
      is_prog = 1'b0;
      is_e4 = 1'b0;
      is_e32 = 1'b0;
      is_e64 = 1'b0;
      is_chip = 1'b0;
      is_addr4 = s_ff.cfg[`BWPL_CFG_ADDR4];
      unique case (s_ff.opcode)
         `BWPL_OP_PP3, `BWPL_OP_PPQ3A, `BWPL_OP_PPQ3B: is_prog = 1'b1;
         `BWPL_OP_PP4, `BWPL_OP_PPQ4A, `BWPL_OP_PPQ4B: begin
            is_prog = 1'b1;
            is_addr4 = 1'b1;
         end
         `BWPL_OP_SE3A, `BWPL_OP_SE3B: is_e4 = 1'b1;
         `BWPL_OP_SE4: begin
            is_e4 = 1'b1;
            is_addr4 = 1'b1;
         end
         `BWPL_OP_BE32_3: is_e32 = 1'b1;
         `BWPL_OP_BE32_4: begin
            is_e32 = 1'b1;
            is_addr4 = 1'b1;
         end
         `BWPL_OP_BE64_3: is_e64 = 1'b1;
         `BWPL_OP_BE64_4: begin
            is_e64 = 1'b1;
            is_addr4 = 1'b1;
         end
         `BWPL_OP_CHIP_A, `BWPL_OP_CHIP_B: is_chip = 1'b1;
         default: ;
      endcase
      if (is_prog | is_e4 | is_e32 | is_e64) begin
         need = is_addr4 ? 3'd4 : 3'd3;
      end else if (s_ff.opcode == `BWPL_OP_STATUS_WR || s_ff.opcode == `BWPL_OP_RDPV_NOWE ||
                   s_ff.opcode == `BWPL_OP_RDPV_WE || s_ff.opcode == `BWPL_OP_BANKV_NOWE ||
                   s_ff.opcode == `BWPL_OP_BANKV_WE) begin
         need = 3'd1;
      end else begin
         need = 3'd0;
      end
      // Program must carry at least one data byte after its address
      len_ok = s_ff.have_op && s_ff.bit_cnt == 3'd0 &&
               (is_prog ? (s_ff.nbytes > need) : (s_ff.nbytes == need));
   end

   // ==========================================================
   // Range check on the target block
   always_comb begin
      target = is_addr4 ? s_ff.acc : {8'h00, s_ff.acc[23:0]};
      if (s_ff.cfg[`BWPL_CFG_ORG256]) begin
         blk = {2'b00, target[ADDR_W-1:`BWPL_BLK256_SHIFT]};
         total = `BWPL_BLK256_TOTAL;
      end else begin
         blk = target[ADDR_W-1:`BWPL_BLK64_SHIFT];
         total = `BWPL_BLK64_TOTAL;
      end
      pcnt = prot_count(s_ff.status[`BWPL_SR_BP_HI:`BWPL_SR_BP_LO],
                        s_ff.cfg[`BWPL_CFG_ORG256]);
      // A zero count never hits, so no separate none case is needed
      if (s_ff.cfg[`BWPL_CFG_BOTTOM]) begin
         hit = {1'b0, blk} < pcnt;
      end else begin
         hit = {1'b0, blk} >= (total - pcnt);
      end
   end

   assign wr_latch = s_ff.status[`BWPL_SR_WR_LATCH];
   assign wb_req = wb_cyc_i & wb_stb_i & ~s_ff.wb_ack;

   always_comb begin
      unique case (wb_adr_i)
         `BWPL_OFF_STATUS: rd_dat = {24'h0000_00, s_ff.status};
         `BWPL_OFF_CONFIG: rd_dat = {29'h0000_0000, s_ff.cfg};
         `BWPL_OFF_RESULT: rd_dat = {20'h0000_0, s_ff.result};
         default: rd_dat = 32'h0000_0000;
      endcase
   end

   // ==========================================================
   // Next state
   always_comb begin
      nxt_s = s_ff;
      nxt_s.req.valid = 1'b0;
      nxt_s.vol.valid = 1'b0;
      nxt_s.refused = 1'b0;
      nxt_s.wb_ack = 1'b0;
      nxt_s.sync1 = pins_in;
      nxt_s.sync2 = s_ff.sync1;
      nxt_s.prev_cs_n = s_ff.sync2.cs_n;
      nxt_s.prev_sck = s_ff.sync2.sck;

      if (array_done) begin
         nxt_s.status[`BWPL_SR_WIP] = 1'b0;
      end

      if (cs_fall) begin
         nxt_s.bit_cnt = 3'd0;
         nxt_s.have_op = 1'b0;
         nxt_s.nbytes = 3'd0;
      end else if (sck_rise) begin
         nxt_s.shift = shifted;
         nxt_s.bit_cnt = s_ff.bit_cnt + 3'd1;
         if (s_ff.bit_cnt == 3'd7) begin
            if (!s_ff.have_op) begin
               nxt_s.opcode = shifted;
               nxt_s.have_op = 1'b1;
            end else begin
               // Program data beyond the address is counted but not kept
               if (s_ff.nbytes < need) begin
                  nxt_s.acc = {s_ff.acc[23:0], shifted};
               end
               if (s_ff.nbytes != 3'd7) begin
                  nxt_s.nbytes = s_ff.nbytes + 3'd1;
               end
            end
         end
      end

      // Commands act on deselect; a busy array ignores them all
      if (cs_rise && len_ok && !s_ff.status[`BWPL_SR_WIP]) begin
         nxt_s.result = {3'b000, 1'b1, s_ff.opcode};
         if (s_ff.opcode == `BWPL_OP_WR_ENABLE) begin
            nxt_s.status[`BWPL_SR_WR_LATCH] = 1'b1;
         end else if (s_ff.opcode == `BWPL_OP_WRDI) begin
            nxt_s.status[`BWPL_SR_WR_LATCH] = 1'b0;
         end else if (s_ff.opcode == `BWPL_OP_RDPV_NOWE ||
                      s_ff.opcode == `BWPL_OP_BANKV_NOWE) begin
            nxt_s.vol = '{valid: 1'b1, opcode: s_ff.opcode, data: s_ff.acc[7:0]};
         end else if (!wr_latch && need != 3'd0 || !wr_latch && is_chip) begin
            nxt_s.result = {3'b001, 1'b0, s_ff.opcode};
            nxt_s.refused = 1'b1;
         end else if (s_ff.opcode == `BWPL_OP_RDPV_WE || s_ff.opcode == `BWPL_OP_BANKV_WE) begin
            nxt_s.vol = '{valid: 1'b1, opcode: s_ff.opcode, data: s_ff.acc[7:0]};
         end else if (s_ff.opcode == `BWPL_OP_STATUS_WR) begin
            if (s_ff.status[`BWPL_SR_SWD] && !wp_level) begin
               nxt_s.result = {3'b100, 1'b0, s_ff.opcode};
               nxt_s.refused = 1'b1;
            end else begin
               // Only the six upper bits (protect code, quad, lock) follow the byte; the write latch clears and busy sets
               nxt_s.status[`BWPL_SR_SWD:`BWPL_SR_BP_LO] =
                  s_ff.acc[`BWPL_SR_SWD:`BWPL_SR_BP_LO];
               nxt_s.status[`BWPL_SR_WR_LATCH] = 1'b0;
               nxt_s.status[`BWPL_SR_WIP] = 1'b1;
               nxt_s.req = '{valid: 1'b1, kind: bwpl_pkg::BWPL_STATUS_WR,
                             addr: 32'h0000_0000};
            end
         end else if (is_chip) begin
            if (s_ff.status[`BWPL_SR_BP_HI:`BWPL_SR_BP_LO] != 4'h0) begin
               nxt_s.result = {3'b010, 1'b0, s_ff.opcode};
               nxt_s.refused = 1'b1;
            end else begin
               nxt_s.status[`BWPL_SR_WR_LATCH] = 1'b0;
               nxt_s.status[`BWPL_SR_WIP] = 1'b1;
               nxt_s.req = '{valid: 1'b1, kind: bwpl_pkg::BWPL_ERASE_CHIP,
                             addr: 32'h0000_0000};
            end
         end else if (is_prog | is_e4 | is_e32 | is_e64) begin
            if (hit) begin
               nxt_s.result = {3'b010, 1'b0, s_ff.opcode};
               nxt_s.refused = 1'b1;
            end else begin
               nxt_s.status[`BWPL_SR_WR_LATCH] = 1'b0;
               nxt_s.status[`BWPL_SR_WIP] = 1'b1;
               nxt_s.req.valid = 1'b1;
               nxt_s.req.addr = target;
               if (is_prog) begin
                  nxt_s.req.kind = bwpl_pkg::BWPL_PROG;
               end else if (is_e4) begin
                  nxt_s.req.kind = bwpl_pkg::BWPL_ERASE_4K;
               end else if (is_e32) begin
                  nxt_s.req.kind = bwpl_pkg::BWPL_ERASE_32K;
               end else begin
                  nxt_s.req.kind = bwpl_pkg::BWPL_ERASE_64K;
               end
            end
         end else begin
            nxt_s.result = {3'b000, 1'b0, s_ff.opcode};
         end
      end

      // Wishbone: one wait state, ack dropped in the following cycle
      if (wb_req) begin
         nxt_s.wb_ack = 1'b1;
         nxt_s.wb_dat = wb_we_i ? 32'h0000_0000 : rd_dat;
         if (wb_we_i && wb_sel_i[0] && wb_adr_i == `BWPL_OFF_CONFIG) begin
            nxt_s.cfg[`BWPL_CFG_ORG256] = wb_dat_i[`BWPL_CFG_ORG256];
            nxt_s.cfg[`BWPL_CFG_ADDR4] = wb_dat_i[`BWPL_CFG_ADDR4];
            nxt_s.cfg[`BWPL_CFG_BOTTOM] = s_ff.cfg[`BWPL_CFG_BOTTOM] |
                                          wb_dat_i[`BWPL_CFG_BOTTOM];
         end
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge clk) begin
      if (reset) begin
         s_ff <= '0;
         s_ff.sync1 <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, wp: 1'b1, hold: 1'b1};
         s_ff.sync2 <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, wp: 1'b1, hold: 1'b1};
         s_ff.prev_cs_n <= 1'b1;
         s_ff.status <= `BWPL_SR_RESET;
         s_ff.cfg <= `BWPL_CFG_RESET;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign op_valid = s_ff.req.valid;
   assign op_kind = s_ff.req.kind;
   assign op_addr = s_ff.req.addr;
   assign vol_valid = s_ff.vol.valid;
   assign vol_opcode = s_ff.vol.opcode;
   assign vol_data = s_ff.vol.data;
   assign cmd_refused = s_ff.refused;
   assign status_reg = s_ff.status;
   assign wb_ack_o = s_ff.wb_ack;
   assign wb_dat_o = s_ff.wb_dat;

endmodule

// *** test/bwpl_protect_monitor.sv ***
// Concurrent checks on the top ports of the write protect block.
// Assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/1ps
module bwpl_protect_monitor (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Observed outputs and bus
   input wire logic data_line_two_oe,
   input wire logic data_line_three_oe,
   input wire logic op_valid,
   input wire bwpl_pkg::bwpl_op_e op_kind,
   input wire logic vol_valid,
   input wire logic cmd_refused,
   input wire logic [7:0] status_reg,
   input wire logic quad_mode,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // ==========================================================
   // Assertions
   a_wb_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing one cycle after request");
   a_wb_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_quad_mode_copy: assert property (quad_mode == status_reg[6])
      else $error("quad mode differs from quad enable bit");
   a_pins_never_driven: assert property (!data_line_two_oe && !data_line_three_oe)
      else $error("control pin driven");
   a_chip_erase_clear: assert property (
      op_valid && op_kind == bwpl_pkg::BWPL_ERASE_CHIP |-> status_reg[5:2] == 4'h0)
      else $error("chip erase accepted with protect code set");
   a_lock_bits_written: assert property (
      $changed(status_reg[7:2]) |-> op_valid && op_kind == bwpl_pkg::BWPL_STATUS_WR)
      else $error("status bits changed without status write");
   a_accept_sets_busy: assert property (op_valid |-> status_reg[1:0] == 2'b01)
      else $error("accepted op did not set busy and clear latch");
   a_busy_no_accept: assert property (op_valid |-> !$past(status_reg[0]))
      else $error("op accepted while busy");
   a_accept_or_refuse: assert property (!(op_valid && (cmd_refused || vol_valid)))
      else $error("command both accepted and refused");
   a_refuse_single: assert property (cmd_refused |=> !cmd_refused)
      else $error("refusal pulse longer than one cycle");
   // ==========================================================
   // Covers
   c_erase: cover property (op_valid && op_kind == bwpl_pkg::BWPL_ERASE_64K);
   c_refuse: cover property (cmd_refused);
   c_vol: cover property (vol_valid);
   c_quad: cover property (quad_mode);
endmodule

bind bwpl_block_write_protect bwpl_protect_monitor u_mon (.clk, .reset, .data_line_two_oe,
   .data_line_three_oe, .op_valid, .op_kind, .vol_valid, .cmd_refused, .status_reg,
   .quad_mode, .wb_cyc_i, .wb_stb_i, .wb_ack_o);

// *** test/bwpl_spi_host.sv ***
// Mode 0 serial host model that frames commands for the protect block.
// Assumes a free-running clk; sck is derived from it and stands low between frames.
`timescale 1ns/1ps
module bwpl_spi_host (
   // Clock
   input wire logic clk,
   // Pins toward the device
   output bwpl_pkg::bwpl_pins_s pins
);
   // Protect and hold pins idle high; the bench sets quad enable with the protect pin driven low
   initial pins = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, wp: 1'b1, hold: 1'b1};
   // Deselected data line toggles so stale bits cannot look valid
   always @(posedge clk) begin
      if (pins.cs_n)
         pins.si <= ~pins.si;
   end
   task automatic send(input int n, input logic [47:0] d);
      @(posedge clk);
      pins.cs_n <= 1'b0;
      @(posedge clk);
      for (int i = 0; i < n * 8; i++) begin
         pins.si <= d[47 - i];
         repeat (4) @(posedge clk);
         pins.sck <= 1'b1;
         repeat (4) @(posedge clk);
         pins.sck <= 1'b0;
      end
      repeat (4) @(posedge clk);
      pins.cs_n <= 1'b1;
      @(posedge clk);
   endtask
   task automatic set_wp(input logic v);
      @(posedge clk);
      pins.wp <= v;
   endtask
   task automatic set_hold(input logic v);
      @(posedge clk);
      pins.hold <= v;
   endtask
endmodule

// *** test/test_bwpl_block_write_protect.sv ***
// Self-checking bench for the write protect block.
// Assumes the host model on the link side and a Wishbone master task here.
`timescale 1ns/1ps
`include "bwpl_regs.svh"
module test_bwpl_block_write_protect;
   logic clk = 1'b0, reset = 1'b1, array_done = 1'b0;
   logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack;
   logic [7:0] wb_adr = 8'h00, vol_op, vol_dat, status_reg;
   logic [31:0] wb_wdat = 32'h0000_0000, wb_rdat, rd, op_addr, got_addr;
   logic op_valid, vol_valid, cmd_refused, quad_mode;
   logic [15:0] got_vol;
   bwpl_pkg::bwpl_op_e op_kind, got_kind;
   bwpl_pkg::bwpl_pins_s pins;
   int failures = 0, checked = 0;
   initial forever #12.5 clk = ~clk;
   bwpl_spi_host host (.clk(clk), .pins(pins));
   bwpl_block_write_protect dut (.clk(clk), .reset(reset), .cs_n_pin(pins.cs_n),
      .sck_pin(pins.sck), .si_pin(pins.si), .data_line_two_i(pins.wp),
      .data_line_two_o(), .data_line_two_oe(), .data_line_three_i(pins.hold),
      .data_line_three_o(), .data_line_three_oe(), .op_valid(op_valid), .op_kind(op_kind),
      .op_addr(op_addr), .array_done(array_done), .vol_valid(vol_valid),
      .vol_opcode(vol_op), .vol_data(vol_dat), .cmd_refused(cmd_refused),
      .status_reg(status_reg), .quad_mode(quad_mode), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_wdat),
      .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack));
   // ==========================================================
   // Shared tasks
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      int n;
      n = 0;
      @(posedge clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= adr;
      wb_wdat <= dat;
      @(posedge clk);
      while (wb_ack !== 1'b1 && n < 50) begin
         @(posedge clk);
         n++;
      end
      check(32'(wb_ack), 32'h0000_0001);
      rd = wb_rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask
   // Outcome code: 0 none, 1 accepted op, 2 volatile write, 3 refused
   task automatic cmd(input int n, input logic [47:0] d, input logic [1:0] exp);
      logic [1:0] got;
      got = 2'd0;
      host.send(n, d);
      repeat (10) begin
         @(posedge clk);
         if (op_valid === 1'b1) begin
            got = 2'd1;
            got_addr = op_addr;
            got_kind = op_kind;
         end
         if (vol_valid === 1'b1) begin
            got = 2'd2;
            got_vol = {vol_op, vol_dat};
         end
         if (cmd_refused === 1'b1)
            got = 2'd3;
      end
      check(32'(got), 32'(exp));
      if (got == 2'd1) begin
         array_done <= 1'b1;
         @(posedge clk);
         array_done <= 1'b0;
      end
   endtask
   task automatic write_enable();
      cmd(1, {`BWPL_OP_WR_ENABLE, 40'h0}, 2'd0);
   endtask
   task automatic set_status(input logic [7:0] v, input logic [1:0] exp);
      write_enable();
      cmd(2, {`BWPL_OP_STATUS_WR, v, 32'h0}, exp);
   endtask
   function automatic int prot_cnt(input logic org, input int c);
      if (c == 0) return 0;
      if (org) return (c >= 9) ? 256 : 1 << (c - 1);
      if (c <= 10) return 1 << (c - 1);
      return (c == 11) ? 768 : (c == 12) ? 896 : (c == 13) ? 960 : (c == 14) ? 992 : 1024;
   endfunction
   task automatic erase(input logic org, input int blk, input logic [1:0] exp);
      logic [31:0] a;
      a = 32'(blk) << (org ? 18 : 16);
      write_enable();
      cmd(5, {`BWPL_OP_BE64_4, a, 8'h00}, exp);
      if (exp == 2'd1)
         check(got_addr, a);
   endtask
   task automatic sweep(input logic org, input logic bottom);
      int cnt, tot;
      tot = org ? 256 : 1024;
      for (int c = 0; c < 16; c++) begin
         set_status({2'b00, 4'(c), 2'b00}, 2'd1);
         cnt = prot_cnt(org, c);
         if (cnt > 0)
            erase(org, bottom ? cnt - 1 : tot - cnt, 2'd3);
         if (cnt < tot)
            erase(org, bottom ? cnt : tot - cnt - 1, 2'd1);
      end
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_regs();
      wb(1'b1, `BWPL_OFF_STATUS, 32'h0000_00ff);
      wb(1'b0, `BWPL_OFF_STATUS, 32'h0000_0000);
      check(rd, 32'h0000_0000);
      wb(1'b0, `BWPL_OFF_CONFIG, 32'h0000_0000);
      check(rd, 32'h0000_0000);
      wb(1'b0, 8'h0c, 32'h0000_0000);
      check(rd, 32'h0000_0000);
   endtask
   task automatic t_latch();
      cmd(6, {`BWPL_OP_PP4, 32'h0001_0000, 8'ha5}, 2'd3);
      wb(1'b0, `BWPL_OFF_RESULT, 32'h0000_0000);
      check(rd, 32'h0000_0212);
      write_enable();
      cmd(6, {`BWPL_OP_PP4, 32'h0001_0000, 8'ha5}, 2'd1);
      check(got_addr, 32'h0001_0000);
      check(32'(got_kind), 32'(bwpl_pkg::BWPL_PROG));
   endtask
   task automatic t_vol();
      cmd(2, {`BWPL_OP_RDPV_NOWE, 8'h5a, 32'h0}, 2'd2);
      check(32'(got_vol), 32'h0000_c05a);
      cmd(2, {`BWPL_OP_BANKV_NOWE, 8'h3c, 32'h0}, 2'd2);
      check(32'(got_vol), 32'h0000_173c);
      cmd(2, {`BWPL_OP_RDPV_WE, 8'h5a, 32'h0}, 2'd3);
   endtask
   task automatic t_lock();
      host.set_wp(1'b0);
      set_status(8'h80, 2'd1);
      set_status(8'h04, 2'd3);
      check(32'(status_reg[7:2]), 32'h0000_0020);
      host.set_wp(1'b1);
      set_status(8'h00, 2'd1);
      check(32'(status_reg[7:2]), 32'h0000_0000);
      host.set_wp(1'b0);
      set_status(8'hc0, 2'd1);
      check(32'(quad_mode), 32'h0000_0001);
      // Quad on turns the lock pin into a data line, so the lock is lifted
      set_status(8'h00, 2'd1);
      check(32'(quad_mode), 32'h0000_0000);
      host.set_wp(1'b1);
   endtask
   task automatic t_chip();
      set_status(8'h08, 2'd1);
      write_enable();
      cmd(1, {`BWPL_OP_CHIP_A, 40'h0}, 2'd3);
      set_status(8'h00, 2'd1);
      write_enable();
      cmd(1, {`BWPL_OP_CHIP_B, 40'h0}, 2'd1);
      check(32'(got_kind), 32'(bwpl_pkg::BWPL_ERASE_CHIP));
   endtask
   // Three-byte opcodes, the other erase sizes, latch clear and the hold pin
   task automatic t_kinds();
      write_enable();
      cmd(4, {`BWPL_OP_SE3B, 24'h01_2345, 16'h0}, 2'd1);
      check(got_addr, 32'h0001_2345);
      check(32'(got_kind), 32'(bwpl_pkg::BWPL_ERASE_4K));
      write_enable();
      cmd(4, {`BWPL_OP_BE32_3, 24'h00_8000, 16'h0}, 2'd1);
      check(32'(got_kind), 32'(bwpl_pkg::BWPL_ERASE_32K));
      write_enable();
      cmd(2, {`BWPL_OP_BANKV_WE, 8'h11, 32'h0}, 2'd2);
      check(32'(got_vol), 32'h0000_c511);
      cmd(1, {`BWPL_OP_WRDI, 40'h0}, 2'd0);
      cmd(4, {`BWPL_OP_BE64_3, 24'h00_0000, 16'h0}, 2'd3);
      // Hold low with quad off freezes shifting, so the latch stays clear
      host.set_hold(1'b0);
      write_enable();
      check(32'(status_reg[1]), 32'h0000_0000);
      host.set_hold(1'b1);
      wb(1'b1, `BWPL_OFF_CONFIG, 32'h0000_0002);
      write_enable();
      cmd(5, {`BWPL_OP_BE64_3, 32'h0123_0000, 8'h00}, 2'd1);
      check(got_addr, 32'h0123_0000);
      check(32'(got_kind), 32'(bwpl_pkg::BWPL_ERASE_64K));
      wb(1'b1, `BWPL_OFF_CONFIG, 32'h0000_0000);
   endtask
   task automatic t_sweeps();
      sweep(1'b0, 1'b0);
      wb(1'b1, `BWPL_OFF_CONFIG, 32'h0000_0001);
      sweep(1'b1, 1'b0);
      wb(1'b1, `BWPL_OFF_CONFIG, 32'h0000_0005);
      wb(1'b1, `BWPL_OFF_CONFIG, 32'h0000_0001);
      wb(1'b0, `BWPL_OFF_CONFIG, 32'h0000_0000);
      check(rd, 32'h0000_0005);
      sweep(1'b1, 1'b1);
      wb(1'b1, `BWPL_OFF_CONFIG, 32'h0000_0000);
      sweep(1'b0, 1'b1);
   endtask
   task automatic final_report();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      repeat (3) @(posedge clk);
      t_regs();
      t_latch();
      t_vol();
      t_lock();
      t_chip();
      t_kinds();
      t_sweeps();
      final_report();
   end
   // Sweeps dominate the run at roughly 60000 cycles; the limit keeps a hang short
   initial begin
      repeat (90000) @(posedge clk);
      failures++;
      final_report();
   end
endmodule
